// ---- logic/cbx_pkg.sv ----
package cbx_pkg;
    // ************************************************
    // Register map
    // ************************************************
    localparam logic [7:0]  REG_CMD      = 8'h00;
    localparam logic [7:0]  REG_STATUS   = 8'h04;
    localparam logic [7:0]  REG_DATA     = 8'h08;
    localparam logic [7:0]  REG_TBL_ADDR = 8'h0c;
    localparam logic [7:0]  REG_TBL_DATA = 8'h10;
    localparam logic [7:0]  REG_SENSOR   = 8'h14;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    localparam int          CMD_LEN_LSB  = 16;
    localparam int          CMD_RD_BIT   = 24;
    localparam int          CMD_WR_BIT   = 25;
    localparam int          SEN_SUP_BIT  = 8;
    localparam int          SEN_BAT_BIT  = 9;
    // ************************************************
    // Parameter numbers
    // ************************************************
    localparam logic [15:0] PAR_CAL_ACC  = 16'h0201;
    localparam logic [15:0] PAR_CAL_GYR  = 16'h0203;
    localparam logic [15:0] PAR_CAL_MAG  = 16'h0205;
    localparam logic [15:0] PAR_SOFT_IRN = 16'h027d;
    localparam logic [15:0] PAR_VERSION  = 16'h027e;
    localparam logic [15:0] PAR_INFO_LO  = 16'h0301;
    localparam logic [15:0] PAR_INFO_HI  = 16'h0395;
    localparam logic [15:0] PAR_CFG_LO   = 16'h0501;
    localparam logic [15:0] PAR_CFG_HI   = 16'h0595;
    // ************************************************
    // Structure sizes and fields
    // ************************************************
    localparam logic [7:0]  BLK_DATA_MAX = 8'h40;
    localparam logic [7:0]  XFER_LEN     = 8'h44;
    localparam logic [7:0]  HDR_BYTES    = 8'h04;
    localparam logic [15:0] STATE_MAX    = 16'h0100;
    localparam logic [15:0] VER_LEN      = 16'h0004;
    localparam logic [15:0] INFO_LEN     = 16'h001c;
    localparam logic [15:0] CFG_LEN      = 16'h000c;
    localparam int          DONE_BIT     = 7;
    localparam logic [1:0]  SLOT_SOFT    = 2'h3;
    localparam logic [3:0]  TBL_PER_ID   = 4'ha;
    localparam logic [3:0]  CFG_WORD0    = 4'h7;
    localparam logic [1:0]  CFG_LAT_WORD = 2'h1;
    localparam int          TBL_DEPTH    = 1500;
    localparam int          WBUF_WORDS   = 17;
    localparam logic [7:0]  SENSOR_MAX   = 8'h95;
    // Version bytes, arbitrary values
    localparam logic [31:0] VERSION_WORD = 32'h00_00_01_01;

    typedef enum logic [2:0] {
        K_NONE = 3'b000,
        K_CAL  = 3'b001,
        K_VER  = 3'b010,
        K_INFO = 3'b011,
        K_CFG  = 3'b100
    } cbx_kind_t;

    typedef enum logic [0:0] {
        S_IDLE = 1'b0,
        S_COPY = 1'b1
    } cbx_fsm_t;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } cbx_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } cbx_axi_rsp_t;

    typedef struct packed {
        cbx_axi_rsp_t         rsp;
        logic                 aw_full;
        logic [7:0]           aw_addr;
        logic                 w_full;
        logic [31:0]          w_data;
        logic [3:0]           w_strb;
        cbx_fsm_t             fsm;
        cbx_kind_t            kind;
        logic [1:0]           slot;
        logic [15:0]          param;
        logic [7:0]           wlen;
        logic                 ready;
        logic                 err;
        logic [15:0]          resp_len;
        logic [7:0]           rd_ptr;
        logic [4:0]           wr_ptr;
        logic [7:0]           blk_info;
        logic [7:0]           blen;
        logic [15:0]          total;
        logic [6:0]           cnt;
        logic [3:0][6:0]      rd_blk;
        logic [3:0]           bank;
        logic [3:0][1:0][8:0] slen;
        logic [10:0]          tbl_addr;
        logic [149:0]         sup;
        logic [149:0]         batch;
    } cbx_state_t;

    localparam cbx_state_t STATE_RST = '0;
endpackage : cbx_pkg

// ---- logic/cbx_param_engine.sv ----
// Summary of operation
// - Read blocks carry at most 64 data bytes
// - Completion flag only in final read block
// - Info byte: block number low, done top
// - Payload at most 68 bytes, fixed layout
// - Calibration 0x0201, 0x0203, 0x0205, soft iron 0x027D
// - Version read returns four version bytes
// - Sensor info 0x0301-0x0395, id from low byte
// - Unsupported sensor returns all-zero structure
// - Multi-byte fields least significant byte first
// - Info length 28, first byte sensor id
// - Power byte in 0.1 mA steps
// - Rate limits as 32-bit float hertz
// - Max range fixed, independent of setting
// - Config 0x0501-0x0595 returns 12 bytes
// - Config sample rate is actual rate
// - Latency reads zero when not batching
// - Dynamic range of physical sensor, native units
// - Event size byte counts type byte
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
module cbx_param_engine
    import cbx_pkg::*;
(
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    // Register bus
    input  wire cbx_axi_req_t axi_req,
    output cbx_axi_rsp_t      axi_rsp
);
    // ************************************************
    // State and memories
    // ************************************************
    cbx_state_t  s_r;
    cbx_state_t  s_nxt;
    logic [7:0]  cal_mem [0:2047];
    logic [31:0] tbl_mem [0:TBL_DEPTH-1];
    logic [31:0] wbuf_mem [0:WBUF_WORDS-1];
    logic        cal_we;
    logic [10:0] cal_wa;
    logic [7:0]  cal_wd;
    logic        tbl_we;
    logic        wbuf_we;
    logic [31:0] mem_wd;
    logic        apply_now;
    logic [3:0][7:0] lane;

    // Parameter number to transfer kind
    function automatic cbx_kind_t kind_of(input logic [15:0] p);
        if (p == PAR_CAL_ACC || p == PAR_CAL_GYR || p == PAR_CAL_MAG || p == PAR_SOFT_IRN)
            return K_CAL;
        if (p == PAR_VERSION)
            return K_VER;
        if (p >= PAR_INFO_LO && p <= PAR_INFO_HI)
            return K_INFO;
        if (p >= PAR_CFG_LO && p <= PAR_CFG_HI)
            return K_CFG;
        return K_NONE;
    endfunction : kind_of

    // Calibration parameter to storage slot
    function automatic logic [1:0] slot_of(input logic [15:0] p);
        if (p == PAR_CAL_GYR)
            return 2'h1;
        if (p == PAR_CAL_MAG)
            return 2'h2;
        if (p == PAR_SOFT_IRN)
            return SLOT_SOFT;
        return 2'h0;
    endfunction : slot_of

    // ************************************************
    // Response byte lanes
    // ************************************************
    for (genvar g = 0; g < 4; g++) begin : g_lane
        always_comb begin
            logic [7:0]  idx;
            logic [7:0]  p;
            logic [10:0] ta;
            logic [7:0]  off;
            logic [31:0] tw;
            idx  = s_r.rd_ptr + 8'(g);
            p    = idx - HDR_BYTES;
            ta   = 11'(s_r.param[7:0]) * 11'(TBL_PER_ID);
            off  = {s_r.blk_info[1:0], 6'h00} + p - HDR_BYTES;
            tw   = '0;
            lane[g] = 8'h00;
            if (idx < HDR_BYTES) begin
                lane[g] = 8'({s_r.resp_len, s_r.param} >> {idx[1:0], 3'h0});
            end else if (16'(p) < s_r.resp_len) begin
                unique case (s_r.kind)
                    K_VER: lane[g] = 8'(VERSION_WORD >> {p[1:0], 3'h0});
                    K_INFO: begin
                        tw = tbl_mem[ta + 11'(p[7:2])];
                        if (!s_r.sup[s_r.param[7:0]])
                            lane[g] = 8'h00;
                        else if (p == 8'h00)
                            lane[g] = s_r.param[7:0];
                        else
                            lane[g] = 8'(tw >> {p[1:0], 3'h0});
                    end
                    K_CFG: begin
                        tw = tbl_mem[ta + 11'(CFG_WORD0) + 11'(p[3:2])];
                        if (!s_r.sup[s_r.param[7:0]])
                            lane[g] = 8'h00;
                        else if (p[3:2] == CFG_LAT_WORD && !s_r.batch[s_r.param[7:0]])
                            lane[g] = 8'h00;
                        else
                            lane[g] = 8'(tw >> {p[1:0], 3'h0});
                    end
                    K_CAL: begin
                        if (p == 8'h00)
                            lane[g] = s_r.blk_info;
                        else if (p == 8'h01)
                            lane[g] = s_r.blen;
                        else if (p < HDR_BYTES)
                            lane[g] = 8'(s_r.total >> {p[0], 3'h0});
                        else
                            lane[g] = cal_mem[{s_r.slot, s_r.bank[s_r.slot], off}];
                    end
                    default: lane[g] = 8'h00;
                endcase
            end
        end
    end

    // ************************************************
    // Next-state logic
    // ************************************************
    always_comb begin
        logic [31:0] wd;
        logic [31:0] w0;
        logic [15:0] remain;
        logic [6:0]  blk;
        logic [6:0]  widx;
        logic [31:0] wb;
        s_nxt   = s_r;
        cal_we  = 1'b0;
        cal_wa  = '0;
        cal_wd  = '0;
        tbl_we  = 1'b0;
        wbuf_we = 1'b0;
        apply_now = 1'b0;
        wd      = '0;
        w0      = wbuf_mem[0];
        remain  = '0;
        blk     = s_r.rd_blk[s_r.slot];
        widx    = 7'(HDR_BYTES) + s_r.cnt;
        wb      = wbuf_mem[widx[6:2]];
        for (int i = 0; i < 4; i++)
            wd[i*8 +: 8] = s_r.w_strb[i] ? s_r.w_data[i*8 +: 8] : 8'h00;
        mem_wd = wd;
        // Address and data capture
        if (axi_req.awvalid && s_r.rsp.awready) begin
            s_nxt.aw_full = 1'b1;
            s_nxt.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && s_r.rsp.wready) begin
            s_nxt.w_full = 1'b1;
            s_nxt.w_data = axi_req.wdata;
            s_nxt.w_strb = axi_req.wstrb;
        end
        if (s_r.rsp.bvalid && axi_req.bready)
            s_nxt.rsp.bvalid = 1'b0;
        // Register write
        if (s_r.aw_full && s_r.w_full && !s_r.rsp.bvalid) begin
            s_nxt.aw_full   = 1'b0;
            s_nxt.w_full    = 1'b0;
            s_nxt.rsp.bvalid = 1'b1;
            s_nxt.rsp.bresp = RESP_OKAY;
            unique case (s_r.aw_addr)
                REG_CMD: begin
                    if (s_r.fsm != S_IDLE) begin
                        s_nxt.rsp.bresp = RESP_SLVERR;
                    end else begin
                        s_nxt.param = wd[15:0];
                        s_nxt.wlen  = wd[CMD_LEN_LSB +: 8];
                        s_nxt.kind  = kind_of(wd[15:0]);
                        s_nxt.slot  = slot_of(wd[15:0]);
                        s_nxt.ready = 1'b0;
                        s_nxt.err   = 1'b0;
                        s_nxt.rd_ptr = '0;
                        s_nxt.resp_len = '0;
                        blk = s_r.rd_blk[slot_of(wd[15:0])];
                        if (wd[CMD_RD_BIT]) begin
                            s_nxt.ready = 1'b1;
                            unique case (kind_of(wd[15:0]))
                                K_VER:  s_nxt.resp_len = VER_LEN;
                                K_INFO: s_nxt.resp_len = INFO_LEN;
                                K_CFG:  s_nxt.resp_len = CFG_LEN;
                                K_CAL: begin
                                    remain = 16'(s_r.slen[s_nxt.slot][s_r.bank[s_nxt.slot]])
                                           - 16'({blk, 6'h00});
                                    s_nxt.total = 16'(s_r.slen[s_nxt.slot][s_r.bank[s_nxt.slot]]);
                                    if (remain > 16'(BLK_DATA_MAX)) begin
                                        s_nxt.blen = BLK_DATA_MAX;
                                        s_nxt.blk_info = {1'b0, blk};
                                        s_nxt.rd_blk[s_nxt.slot] = blk + 7'h01;
                                    end else begin
                                        s_nxt.blen = remain[7:0];
                                        s_nxt.blk_info = {1'b1, blk};
                                        s_nxt.rd_blk[s_nxt.slot] = '0;
                                    end
                                    s_nxt.resp_len = 16'(HDR_BYTES) + 16'(s_nxt.blen);
                                    if (s_nxt.slot == SLOT_SOFT) begin
                                        s_nxt.ready = 1'b0;
                                        s_nxt.err   = 1'b1;
                                        s_nxt.rd_blk[s_nxt.slot] = '0;
                                    end
                                end
                                default: begin
                                    s_nxt.ready = 1'b0;
                                    s_nxt.err   = 1'b1;
                                end
                            endcase
                        end else if (wd[CMD_WR_BIT]) begin
                            s_nxt.wr_ptr   = '0;
                            s_nxt.blk_info = w0[7:0];
                            s_nxt.blen     = w0[15:8];
                            s_nxt.total    = w0[31:16];
                            s_nxt.cnt      = '0;
                            if (kind_of(wd[15:0]) != K_CAL || wd[CMD_LEN_LSB +: 8] != XFER_LEN
                                || w0[15:8] > BLK_DATA_MAX || w0[31:16] > STATE_MAX
                                || (!w0[DONE_BIT] && w0[15:8] != BLK_DATA_MAX)
                                || 16'({w0[6:0], 6'h00}) + 16'(w0[15:8]) > w0[31:16])
                                s_nxt.err = 1'b1;
                            else
                                s_nxt.fsm = S_COPY;
                        end
                    end
                end
                REG_DATA: begin
                    if (32'(s_r.wr_ptr) < WBUF_WORDS) begin
                        wbuf_we = 1'b1;
                        s_nxt.wr_ptr = s_r.wr_ptr + 5'h01;
                    end else begin
                        s_nxt.rsp.bresp = RESP_SLVERR;
                    end
                end
                REG_TBL_ADDR: s_nxt.tbl_addr = wd[10:0];
                REG_TBL_DATA: begin
                    tbl_we = 32'(s_r.tbl_addr) < TBL_DEPTH;
                    s_nxt.tbl_addr = s_r.tbl_addr + 11'h001;
                end
                REG_SENSOR: begin
                    if (wd[7:0] <= SENSOR_MAX) begin
                        s_nxt.sup[wd[7:0]]   = wd[SEN_SUP_BIT];
                        s_nxt.batch[wd[7:0]] = wd[SEN_BAT_BIT];
                    end
                end
                default: s_nxt.rsp.bresp = RESP_SLVERR;
            endcase
        end
        // Block copy into the idle bank
        if (s_r.fsm == S_COPY) begin
            if (s_r.cnt == s_r.blen[6:0]) begin
                s_nxt.fsm   = S_IDLE;
                s_nxt.ready = 1'b1;
                if (s_r.blk_info[DONE_BIT]) begin
                    apply_now = 1'b1;
                    s_nxt.bank[s_r.slot] = ~s_r.bank[s_r.slot];
                    s_nxt.slen[s_r.slot][~s_r.bank[s_r.slot]] = s_r.total[8:0];
                    s_nxt.rd_blk[s_r.slot] = '0;
                end
            end else begin
                cal_we = 1'b1;
                cal_wa = {s_r.slot, ~s_r.bank[s_r.slot], {s_r.blk_info[1:0], 6'h00} + 8'(s_r.cnt)};
                cal_wd = 8'(wb >> {widx[1:0], 3'h0});
                s_nxt.cnt = s_r.cnt + 7'h01;
            end
        end
        // Register read
        if (s_r.rsp.rvalid && axi_req.rready)
            s_nxt.rsp.rvalid = 1'b0;
        if (axi_req.arvalid && s_r.rsp.arready) begin
            s_nxt.rsp.rvalid = 1'b1;
            s_nxt.rsp.rresp  = RESP_OKAY;
            s_nxt.rsp.rdata  = '0;
            unique case (axi_req.araddr)
                REG_CMD:      s_nxt.rsp.rdata = {8'h00, s_r.wlen, s_r.param};
                REG_STATUS:   s_nxt.rsp.rdata = {s_r.resp_len, 13'h0000, s_r.err, s_r.ready,
                                                 s_r.fsm == S_COPY};
                REG_DATA: begin
                    s_nxt.rsp.rdata = lane;
                    s_nxt.rd_ptr = s_r.rd_ptr + 8'h04;
                end
                REG_TBL_ADDR: s_nxt.rsp.rdata = 32'(s_r.tbl_addr);
                REG_TBL_DATA: s_nxt.rsp.rdata = tbl_mem[s_r.tbl_addr];
                REG_SENSOR:   s_nxt.rsp.rdata = '0;
                default:      s_nxt.rsp.rresp = RESP_SLVERR;
            endcase
        end
        s_nxt.rsp.awready = !s_nxt.aw_full;
        s_nxt.rsp.wready  = !s_nxt.w_full;
        s_nxt.rsp.arready = !s_nxt.rsp.rvalid;
    end

    // ************************************************
    // Registers and memories
    // ************************************************
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s_r <= STATE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Memory writes
    always_ff @(posedge clk_sys) begin
        if (cal_we)
            cal_mem[cal_wa] <= cal_wd;
        if (tbl_we)
            tbl_mem[s_r.tbl_addr] <= mem_wd;
        if (wbuf_we)
            wbuf_mem[s_r.wr_ptr] <= mem_wd;
    end

    assign axi_rsp = s_r.rsp;

    // ************************************************
    // Assertions
    // ************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence s_cal_ready;
        s_r.ready && s_r.kind == K_CAL && s_r.fsm == S_IDLE && !s_r.err && s_r.resp_len != 16'h0000;
    endsequence
    sequence s_last_copy;
        s_r.fsm == S_COPY && s_r.cnt == s_r.blen[6:0] && s_r.blk_info[DONE_BIT];
    endsequence

    property p_blk_len;
        s_cal_ready |-> s_r.blen <= BLK_DATA_MAX;
    endproperty
    a_blk_len: assert property (p_blk_len) else $error("read block too long");

    property p_done_last;
        s_cal_ready |-> s_r.blk_info[DONE_BIT] == (16'({s_r.blk_info[6:0], 6'h00}) + 16'(s_r.blen) == s_r.total);
    endproperty
    a_done_last: assert property (p_done_last) else $error("completion flag misplaced");

    property p_resp_len;
        s_cal_ready |-> s_r.resp_len == 16'(HDR_BYTES) + 16'(s_r.blen);
    endproperty
    a_resp_len: assert property (p_resp_len) else $error("block length mismatch");

    property p_ver;
        s_r.ready && s_r.kind == K_VER |-> s_r.resp_len == VER_LEN;
    endproperty
    a_ver: assert property (p_ver) else $error("version length wrong");

    property p_info;
        s_r.ready && s_r.kind == K_INFO |-> s_r.resp_len == INFO_LEN;
    endproperty
    a_info: assert property (p_info) else $error("info length wrong");

    property p_cfg;
        s_r.ready && s_r.kind == K_CFG |-> s_r.resp_len == CFG_LEN;
    endproperty
    a_cfg: assert property (p_cfg) else $error("config length wrong");

    property p_info_id;
        s_r.ready && s_r.kind == K_INFO && s_r.rd_ptr == HDR_BYTES && s_r.sup[s_r.param[7:0]]
            |-> lane[0] == 8'(s_r.param - PAR_INFO_LO + 16'h0001);
    endproperty
    a_info_id: assert property (p_info_id) else $error("sensor id wrong");

    property p_unsup;
        (s_r.kind == K_INFO || s_r.kind == K_CFG) && !s_r.sup[s_r.param[7:0]] && s_r.rd_ptr >= HDR_BYTES
            |-> lane == '0;
    endproperty
    a_unsup: assert property (p_unsup) else $error("unsupported sensor not zero");

    property p_lat;
        s_r.kind == K_CFG && s_r.rd_ptr == 8'h08 && !s_r.batch[s_r.param[7:0]] |-> lane == '0;
    endproperty
    a_lat: assert property (p_lat) else $error("latency not zero");

    property p_apply;
        s_last_copy ##1 s_r.fsm == S_IDLE |-> s_r.bank[s_r.slot] != $past(s_r.bank[s_r.slot]);
    endproperty
    a_apply: assert property (p_apply) else $error("bank not switched");

    property p_hold;
        !apply_now |=> s_r.bank == $past(s_r.bank);
    endproperty
    a_hold: assert property (p_hold) else $error("bank switched early");
endmodule : cbx_param_engine

// ---- verification/cbx_host_model.sv ----
module cbx_host_model
    import cbx_pkg::*;
(
    // Clock
    input  wire logic         clk_sys,
    // Register bus
    output cbx_axi_req_t      req,
    input  wire cbx_axi_rsp_t rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    cbx_axi_rsp_t s;
    // Mid-cycle copy, seen as sampled at the next rising edge
    always @(negedge clk_sys) s = rsp;
    initial req = '0;
    // One write, address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        @(posedge clk_sys);
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= v;
        req.wstrb   <= 4'hf;
        req.bready  <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (req.awvalid && s.awready) begin
                req.awvalid <= 1'b0;
                req.awaddr  <= ~a;
            end
            if (req.wvalid && s.wready) begin
                req.wvalid <= 1'b0;
                req.wdata  <= ~v;
            end
        end while (!s.bvalid);
        r = s.bresp;
        req.bready <= 1'b0;
    endtask : wr
    // One read
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        @(posedge clk_sys);
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        req.rready  <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (req.arvalid && s.arready) begin
                req.arvalid <= 1'b0;
                req.araddr  <= ~a;
            end
        end while (!s.rvalid);
        v = s.rdata;
        r = s.rresp;
        req.rready <= 1'b0;
    endtask : rd
endmodule : cbx_host_model

// ---- verification/cbx_param_engine_tb.sv ----
module cbx_param_engine_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cbx_pkg::*;
    logic         clk_sys;
    logic         nrst;
    cbx_axi_req_t req;
    cbx_axi_rsp_t rsp;
    int           fails;
    int           comparisons;
    int           cyc;
    logic [31:0]  d;
    logic [1:0]   r;
    cbx_param_engine cbx_param_engine_i (.clk_sys(clk_sys), .nrst(nrst), .axi_req(req), .axi_rsp(rsp));
    cbx_host_model cbx_host_model_i (.clk_sys(clk_sys), .req(req), .rsp(rsp));
    // Compare and count
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic print_verdict;
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict
    // Bus helpers
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        cbx_host_model_i.wr(a, v, r);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        cbx_host_model_i.rd(a, d, r);
        chk(d, e);
    endtask : rdc
    // Wait for ready, then expect no error
    task automatic poll;
        do begin
            cbx_host_model_i.rd(REG_STATUS, d, r);
        end while (d[1] !== 1'b1);
        chk({29'h0, d[2:0]}, 32'h2);
    endtask : poll
    task automatic cmd_rd(input logic [15:0] p);
        wr(REG_CMD, (32'h1 << CMD_RD_BIT) | {16'h0, p});
        poll();
    endtask : cmd_rd
    // Full 17-word block, header then data
    task automatic blk(input logic [15:0] p, input logic [31:0] h, input logic [31:0] f);
        wr(REG_DATA, h);
        repeat (16) wr(REG_DATA, f);
        wr(REG_CMD, (32'h1 << CMD_WR_BIT) | {8'h0, XFER_LEN, p});
        poll();
    endtask : blk
    // Read one block, check parameter and header word
    task automatic rd_blk(input logic [15:0] p, input logic [31:0] h);
        cmd_rd(p);
        cbx_host_model_i.rd(REG_DATA, d, r);
        chk({16'h0, d[15:0]}, {16'h0, p});
        rdc(REG_DATA, h);
    endtask : rd_blk
    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // Hang limit
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 8000) begin
            fails++;
            $display("MISMATCH %0t timeout", $time);
            print_verdict();
        end
    end
    // Main sequence
    initial begin
        nrst = 1'b0;
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        rd_blk(PAR_CAL_GYR, 32'h0000_0080);
        blk(PAR_CAL_ACC, 32'h0004_0480, 32'h1122_3344);
        rd_blk(PAR_CAL_ACC, 32'h0004_0480);
        rdc(REG_DATA, 32'h1122_3344);
        blk(PAR_SOFT_IRN, 32'h0004_0480, 32'h0);
        $display("test single block done");
        blk(PAR_CAL_MAG, 32'h0044_4000, 32'ha5a5_a5a5);
        rd_blk(PAR_CAL_MAG, 32'h0000_0080);
        blk(PAR_CAL_MAG, 32'h0044_0481, 32'h5a5a_5a5a);
        rd_blk(PAR_CAL_MAG, 32'h0044_4000);
        rdc(REG_DATA, 32'ha5a5_a5a5);
        rd_blk(PAR_CAL_MAG, 32'h0044_0481);
        rdc(REG_DATA, 32'h5a5a_5a5a);
        $display("test two blocks done");
        cmd_rd(PAR_VERSION);
        rdc(REG_DATA, {VER_LEN, PAR_VERSION});
        rdc(REG_DATA, VERSION_WORD);
        $display("test version done");
        wr(REG_SENSOR, 32'h0000_0105);
        wr(REG_TBL_ADDR, 32'h0000_003c);
        wr(REG_TBL_DATA, 32'hffff_ffff);
        wr(REG_TBL_ADDR, 32'h0000_0032);
        wr(REG_TBL_DATA, 32'h4433_2211);
        cmd_rd(16'h0305);
        rdc(REG_DATA, {INFO_LEN, 16'h0305});
        rdc(REG_DATA, 32'h4433_2205);
        cmd_rd(16'h0306);
        rdc(REG_DATA, {INFO_LEN, 16'h0306});
        rdc(REG_DATA, 32'h0);
        wr(REG_TBL_ADDR, 32'h0000_0039);
        wr(REG_TBL_DATA, 32'h3f80_0000);
        wr(REG_TBL_DATA, 32'h0000_0064);
        wr(REG_TBL_DATA, 32'h0012_0000);
        cmd_rd(16'h0505);
        rdc(REG_DATA, {CFG_LEN, 16'h0505});
        rdc(REG_DATA, 32'h3f80_0000);
        rdc(REG_DATA, 32'h0);
        rdc(REG_DATA, 32'h0012_0000);
        wr(REG_SENSOR, 32'h0000_0305);
        cmd_rd(16'h0505);
        rdc(REG_DATA, {CFG_LEN, 16'h0505});
        rdc(REG_DATA, 32'h3f80_0000);
        rdc(REG_DATA, 32'h0000_0064);
        cbx_host_model_i.rd(8'h18, d, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        $display("test sensor done");
        print_verdict();
    end
endmodule : cbx_param_engine_tb
